//--- cbw_core.sv
// coprocessor board bus and exception unit: reset vector fetch, exception
// stacking and vector jump, bus timeout, board on/off and host address offset
// assumes one 125 MHz clock, host memory answers with transfer_ack
//
// How it works
// - watchdog raises bus error after 180 us without transfer acknowledge on an execution-core cycle; during vector fetch or stacking it halts the board
// - on start, the first eight bytes are fetched before anything runs
// - first four vector bytes load the 32-bit supervisor stack pointer
// - next four bytes load the program counter; execution starts there
// - reset vector is eight bytes; every other vector is four bytes
// - vector table is one kilobyte starting at address zero
// - exception: stop, save state, read 32-bit vector, jump to it
// - bus or address error pushes return address and status word
// - bus or address error also pushes four extra status words
// - processor address zero maps to host address 0x800
// - host on-command starts the board; host reset turns it off
// - board is off while the host runs timing-critical disk transfers
`timescale 1ns/1ps
`include "cbw_defines.svh"
module cbw_core #(
	parameter int WDOG_CYCLES = `CBW_WDOG_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic host_reset,
	input wire logic board_on_command,
	input wire logic disk_busy,
	input wire logic transfer_ack,
	input wire logic [7:0] host_rdata,
	input cbw_pkg::cbw_exec_bus_type exec_bus,
	input wire logic [31:0] exec_pc,
	input wire logic [15:0] processor_status_word,
	input cbw_pkg::cbw_exc_type exc_req,
	output cbw_pkg::cbw_host_bus_type host_bus_q,
	output logic board_on_q,
	output logic run_q,
	output logic halted_q,
	output logic [31:0] program_counter_q,
	output logic [31:0] supervisor_stack_ptr_q,
	output logic [7:0] exec_rdata_q,
	output logic exec_done_q,
	output logic bus_fault_in_q
);
	import cbw_pkg::*;

	cbw_core_state_type s_q, s_d;
	logic issue;
	logic ack;
	logic timeout;
	logic [111:0] frame_shift;

	// processor byte address to host address
	function automatic logic [15:0] cbw_host_addr(input logic [19:0] paddr);
		cbw_host_addr = paddr[15:0] + `CBW_HOST_BASE;
	endfunction

	// byte read cycle at a processor address
	function automatic cbw_host_bus_type cbw_read(input logic [19:0] paddr);
		cbw_read = '{req: 1'b1, we: 1'b0, addr: cbw_host_addr(paddr), wdata: 8'h00};
	endfunction

	assign ack = transfer_ack && s_q.bus.req;
	assign frame_shift = s_q.frame << {s_q.idx, 3'b000};

	// bus timeout watchdog, cancelled when the board is forced off
	cbw_watchdog #(
		.LIMIT(WDOG_CYCLES)
	) u_wdog (
		.clk(clk),
		.rstn(rstn),
		.start(issue),
		.ack(ack || host_reset || disk_busy),
		.timeout_q(timeout)
	);

	// main sequencer
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.fault = 1'b0;
		if (host_reset || disk_busy) begin
			s_d.board_on = 1'b0; // forced off
			s_d.run = 1'b0;
			s_d.halted = 1'b0;
			s_d.bus = '0;
			s_d.st = CBW_OFF;
		end else begin
			unique case (s_q.st)
				CBW_OFF: begin
					if (board_on_command) begin
						s_d.board_on = 1'b1; // explicit on-command
						s_d.idx = 4'h0;
						s_d.paddr = 20'h00000;
						s_d.st = CBW_RESET; // vector fetch comes first
					end
				end
				CBW_RESET: begin
					if (!s_q.bus.req) begin
						s_d.paddr = {16'h0000, s_q.idx}; // bytes 0..7
						s_d.bus = cbw_read(s_d.paddr);
					end else if (ack) begin
						s_d.bus = '0;
						s_d.rbuf = {s_q.rbuf[55:0], host_rdata};
						s_d.idx = s_q.idx + 4'h1;
						if (s_q.idx == `CBW_RESET_VEC_LAST) begin // eight-byte vector
							s_d.supervisor_stack_ptr = s_q.rbuf[55:24]; // first four bytes
							s_d.pc = {s_q.rbuf[23:0], host_rdata}; // next four
							s_d.run = 1'b1;
							s_d.st = CBW_RUN;
						end
					end else if (timeout) begin
						s_d.bus = '0;
						s_d.halted = 1'b1;
						s_d.st = CBW_HALT;
					end
				end
				CBW_RUN: begin
					if (exc_req.valid) begin
						s_d.run = 1'b0; // suspend execution
						s_d.frame = {exc_req.info, exc_req.status, exc_req.ret_pc};
						s_d.vector = exc_req.vector;
						s_d.first = exc_req.group0 ? 4'h0 : `CBW_FRAME_SHORT_START;
						s_d.idx = s_d.first;
						s_d.st = CBW_PUSH;
					end else if (exec_bus.req && !s_q.done) begin
						s_d.paddr = exec_bus.addr;
						s_d.bus = '{req: 1'b1, we: exec_bus.we, addr: cbw_host_addr(exec_bus.addr),
							wdata: exec_bus.wdata};
						s_d.st = CBW_EXEC;
					end
				end
				CBW_EXEC: begin
					if (ack) begin
						s_d.bus = '0;
						s_d.rdata = host_rdata;
						s_d.done = 1'b1;
						s_d.st = CBW_RUN;
					end else if (timeout) begin
						s_d.bus = '0;
						s_d.fault = 1'b1; // bus error line
						s_d.run = 1'b0;
						// access word, faulting address, zero instruction word
						s_d.frame = {11'h000, s_q.bus.we, 4'h0, 12'h000, s_q.paddr, 16'h0000,
							processor_status_word, exec_pc};
						s_d.vector = `CBW_BUS_ERR_VEC;
						s_d.first = 4'h0;
						s_d.idx = 4'h0;
						s_d.st = CBW_PUSH;
					end
				end
				CBW_PUSH: begin
					if (!s_q.bus.req) begin
						// frame sits just below the stack pointer, ascending
						s_d.paddr = 20'(s_q.supervisor_stack_ptr - `CBW_FRAME_LEN + {28'h0000000, s_q.idx});
						s_d.bus = '{req: 1'b1, we: 1'b1, addr: cbw_host_addr(s_d.paddr),
							wdata: frame_shift[111:104]};
					end else if (ack) begin
						s_d.bus = '0;
						s_d.idx = s_q.idx + 4'h1;
						if (s_q.idx == `CBW_FRAME_LAST) begin
							s_d.supervisor_stack_ptr = s_q.supervisor_stack_ptr - `CBW_FRAME_LEN + {28'h0000000, s_q.first};
							s_d.idx = 4'h0;
							s_d.st = CBW_VEC;
						end
					end else if (timeout) begin
						s_d.bus = '0;
						s_d.halted = 1'b1;
						s_d.st = CBW_HALT;
					end
				end
				CBW_VEC: begin
					if (!s_q.bus.req) begin
						s_d.paddr = {10'h000, s_q.vector, s_q.idx[1:0]}; // table at zero
						s_d.bus = cbw_read(s_d.paddr);
					end else if (ack) begin
						s_d.bus = '0;
						s_d.rbuf = {s_q.rbuf[55:0], host_rdata};
						s_d.idx = s_q.idx + 4'h1;
						if (s_q.idx == `CBW_VEC_LAST) begin // four-byte vector
							s_d.pc = {s_q.rbuf[23:0], host_rdata}; // jump
							s_d.run = 1'b1;
							s_d.st = CBW_RUN;
						end
					end else if (timeout) begin
						s_d.bus = '0;
						s_d.halted = 1'b1;
						s_d.st = CBW_HALT;
					end
				end
				CBW_HALT: begin
					s_d.halted = 1'b1; // double fault: wait for host reset or a disk transfer
				end
			endcase
		end
	end

	// new byte cycle starts the watchdog
	assign issue = s_d.bus.req && !s_q.bus.req;

	// state register; reset leaves the board off
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.st <= CBW_OFF;
			s_q.pc <= `CBW_PTR_RESET;
			s_q.supervisor_stack_ptr <= `CBW_PTR_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign host_bus_q = s_q.bus;
	assign board_on_q = s_q.board_on;
	assign run_q = s_q.run;
	assign halted_q = s_q.halted;
	assign program_counter_q = s_q.pc;
	assign supervisor_stack_ptr_q = s_q.supervisor_stack_ptr;
	assign exec_rdata_q = s_q.rdata;
	assign exec_done_q = s_q.done;
	assign bus_fault_in_q = s_q.fault;

	a_off_on_reset: assert property (@(posedge clk) disable iff (!rstn)
		host_reset |=> !board_on_q && !run_q && !host_bus_q.req)
		else $error("board stayed on after host reset");
	a_disk_forces_off: assert property (@(posedge clk) disable iff (!rstn)
		disk_busy |=> !host_bus_q.req && !board_on_q)
		else $error("board used host memory during disk transfer");
	a_reset_fetch_addr: assert property (@(posedge clk) disable iff (!rstn)
		(s_q.st == CBW_RESET && host_bus_q.req) |->
			host_bus_q.addr == `CBW_HOST_BASE + {12'h000, s_q.idx} && !host_bus_q.we)
		else $error("reset vector read at wrong host address");
	a_run_after_fetch: assert property (@(posedge clk) disable iff (!rstn)
		$rose(run_q) |-> $past(s_q.st) == CBW_RESET && $past(s_q.idx) == `CBW_RESET_VEC_LAST
			|| $past(s_q.st) == CBW_VEC && $past(s_q.idx) == `CBW_VEC_LAST)
		else $error("execution started before the vector was read");
	a_vec_in_table: assert property (@(posedge clk) disable iff (!rstn)
		(s_q.st == CBW_VEC && host_bus_q.req) |-> s_q.paddr < `CBW_VEC_TABLE_BYTES)
		else $error("vector read outside the table");
	a_fault_pushes: assert property (@(posedge clk) disable iff (!rstn)
		bus_fault_in_q |-> s_q.st == CBW_PUSH && s_q.idx == 4'h0 && !run_q
			&& s_q.vector == `CBW_BUS_ERR_VEC)
		else $error("bus error did not start a long frame");
	a_push_then_vec: assert property (@(posedge clk) disable iff (!rstn || host_reset || disk_busy)
		(s_q.st == CBW_PUSH && ack && s_q.idx == `CBW_FRAME_LAST) |=>
			s_q.st == CBW_VEC && s_q.idx == 4'h0 && !run_q)
		else $error("vector not fetched after stacking");
	a_ssp_loaded: assert property (@(posedge clk) disable iff (!rstn || host_reset || disk_busy)
		(s_q.st == CBW_RESET && ack && s_q.idx == `CBW_RESET_VEC_LAST) |=>
			supervisor_stack_ptr_q == $past(s_q.rbuf[55:24])
			&& program_counter_q[7:0] == $past(host_rdata) && run_q)
		else $error("reset vector not loaded into pointers");

endmodule // cbw_core

//--- cbw_defines.svh
// named constants for the coprocessor bus watchdog and exception unit
// assumes a 125 MHz core clock; included by the core and watchdog modules
`ifndef CBW_DEFINES_SVH
`define CBW_DEFINES_SVH

// host window: processor location zero sits at this host address
`define CBW_HOST_BASE 16'h0800
// exception vector table size, from address zero upward
`define CBW_VEC_TABLE_BYTES 20'h00400
// last byte index of the reset vector and of an ordinary vector
`define CBW_RESET_VEC_LAST 4'h7
`define CBW_VEC_LAST 4'h3
// bus error vector number
`define CBW_BUS_ERR_VEC 8'h02
// stack frame: last byte index, first index of the short frame, long frame length
`define CBW_FRAME_LAST 4'hd
`define CBW_FRAME_SHORT_START 4'h8
`define CBW_FRAME_LEN 32'h0000000e
// reset value of the pointers before the vector fetch
`define CBW_PTR_RESET 32'h00000000
// watchdog time in microseconds and clock rate in MHz
`define CBW_WDOG_TIME_US 180
`define CBW_CLK_MHZ 125
`define CBW_WDOG_CYCLES (`CBW_WDOG_TIME_US * `CBW_CLK_MHZ)

`endif

//--- cbw_pkg.sv
// types shared by the coprocessor bus watchdog and exception unit
// assumes cbw_defines.svh is on the include path
package cbw_pkg;

	// one byte cycle towards shared host memory
	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} cbw_host_bus_type;

	// byte cycle asked by the execution core, processor addresses
	typedef struct packed {
		logic req;
		logic we;
		logic [19:0] addr;
		logic [7:0] wdata;
	} cbw_exec_bus_type;

	// exception request from the execution core
	typedef struct packed {
		logic valid;
		logic [7:0] vector;
		logic group0;
		logic [63:0] info;
		logic [15:0] status;
		logic [31:0] ret_pc;
	} cbw_exc_type;

	typedef enum logic [2:0] {
		CBW_OFF,
		CBW_RESET,
		CBW_RUN,
		CBW_EXEC,
		CBW_PUSH,
		CBW_VEC,
		CBW_HALT
	} cbw_state_type;

	// whole state of the main unit
	typedef struct packed {
		cbw_state_type st;
		logic board_on;
		logic run;
		logic halted;
		logic done;
		logic fault;
		logic [31:0] pc;
		logic [31:0] supervisor_stack_ptr;
		logic [3:0] idx;
		logic [3:0] first;
		logic [19:0] paddr;
		logic [63:0] rbuf;
		logic [111:0] frame;
		logic [7:0] vector;
		logic [7:0] rdata;
		cbw_host_bus_type bus;
	} cbw_core_state_type;

	// watchdog state
	typedef struct packed {
		logic busy;
		logic [15:0] cnt;
		logic timeout;
	} cbw_wdog_state_type;

endpackage

//--- cbw_watchdog.sv
// bus timeout watchdog: raises a one-cycle timeout when no acknowledge arrives
// assumes start and ack are synchronous single-cycle strobes from the main unit
`timescale 1ns/1ps
`include "cbw_defines.svh"
module cbw_watchdog #(
	parameter int LIMIT = `CBW_WDOG_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic ack,
	output logic timeout_q
);
	import cbw_pkg::*;

	cbw_wdog_state_type s_q, s_d;

	// count while a cycle is open, stop on ack, fire at the limit
	always_comb begin
		s_d = s_q;
		s_d.timeout = 1'b0;
		if (start) begin
			s_d.busy = 1'b1; // each new cycle restarts the count
			s_d.cnt = 16'h0000;
		end else if (s_q.busy && ack) begin
			s_d.busy = 1'b0; // ack in time: stop quietly
		end else if (s_q.busy) begin
			if (s_q.cnt == 16'(LIMIT - 1)) begin
				s_d.timeout = 1'b1; // limit reached: bus error
				s_d.busy = 1'b0;
			end else begin
				s_d.cnt = s_q.cnt + 16'h0001;
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign timeout_q = s_q.timeout;

	a_fire_at_limit: assert property (@(posedge clk) disable iff (!rstn)
		$rose(s_q.timeout) |-> $past(s_q.cnt) == 16'(LIMIT - 1))
		else $error("watchdog fired before the limit");
	a_ack_no_fire: assert property (@(posedge clk) disable iff (!rstn)
		(s_q.busy && ack && !start) |=> !s_q.timeout && !s_q.busy)
		else $error("watchdog fired after ack");
	a_start_restarts: assert property (@(posedge clk) disable iff (!rstn)
		start |=> s_q.busy && s_q.cnt == 16'h0000 ##1 !s_q.timeout)
		else $error("watchdog did not restart");

endmodule // cbw_watchdog

//--- cbw_host_mem.sv
// behavioural host memory that answers the board's byte cycles
// assumes the board holds req, addr, we and wdata until transfer_ack
`timescale 1ns/1ps
module cbw_host_mem (
	input wire logic clk,
	input cbw_pkg::cbw_host_bus_type bus,
	input wire logic [15:0] drop_addr,
	input wire logic [7:0] delay,
	output logic transfer_ack,
	output logic [7:0] host_rdata
);
	import cbw_pkg::*;
	logic [7:0] mem [0:65535]; // host writes vectors here before the on-command
	logic [7:0] cnt;
	// answer after delay cycles; the drop address never answers
	always_ff @(posedge clk) begin
		transfer_ack <= 1'b0;
		if (bus.req && !transfer_ack) begin
			if (cnt == delay && bus.addr != drop_addr) begin
				transfer_ack <= 1'b1;
				host_rdata <= mem[bus.addr];
				if (bus.we) mem[bus.addr] <= bus.wdata;
				cnt <= 8'h00;
			end else cnt <= cnt + 8'h01;
		end else begin
			cnt <= 8'h00;
			if (!transfer_ack) host_rdata <= ~host_rdata; // released data line does not hold
		end
	end
endmodule // cbw_host_mem

//--- coprocessor_bus_watchdog_reset_test.sv
// self-checking bench for the board's bus watchdog and exception unit
// assumes cbw_pkg and the host memory model are compiled first
`timescale 1ns/1ps
module coprocessor_bus_watchdog_reset_test;
	import cbw_pkg::*;
	localparam int WDOG = 20;
	logic clk, rstn, host_reset, board_on_command, disk_busy, transfer_ack, seen, low;
	logic [7:0] host_rdata, delay, exec_rdata_q;
	logic [15:0] drop_addr, psw, hadr;
	logic [31:0] exec_pc, program_counter_q, supervisor_stack_ptr_q;
	cbw_exec_bus_type exec_bus;
	cbw_exc_type exc_req;
	cbw_host_bus_type host_bus_q;
	logic board_on_q, run_q, halted_q, exec_done_q, bus_fault_in_q;
	int fails, samples_checked, n;
	cbw_core #(.WDOG_CYCLES(WDOG)) u_cbw_core (.clk(clk), .rstn(rstn), .host_reset(host_reset),
		.board_on_command(board_on_command), .disk_busy(disk_busy),
		.transfer_ack(transfer_ack), .host_rdata(host_rdata), .exec_bus(exec_bus),
		.exec_pc(exec_pc), .processor_status_word(psw), .exc_req(exc_req),
		.host_bus_q(host_bus_q), .board_on_q(board_on_q), .run_q(run_q),
		.halted_q(halted_q), .program_counter_q(program_counter_q),
		.supervisor_stack_ptr_q(supervisor_stack_ptr_q), .exec_rdata_q(exec_rdata_q),
		.exec_done_q(exec_done_q), .bus_fault_in_q(bus_fault_in_q));
	cbw_host_mem u_cbw_host_mem (.clk(clk), .bus(host_bus_q), .drop_addr(drop_addr),
		.delay(delay), .transfer_ack(transfer_ack), .host_rdata(host_rdata));
	// compare and count
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic print_verdict();
		if (fails == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// host byte behind a processor address
	function automatic logic [7:0] hb(input logic [19:0] pa);
		return u_cbw_host_mem.mem[pa[15:0] + 16'h0800];
	endfunction
	task automatic put32(input logic [15:0] ha, input logic [31:0] v);
		for (int i = 0; i < 4; i++) u_cbw_host_mem.mem[ha + 16'(i)] = v[31 - 8*i -: 8];
	endtask
	// wait until run_q has gone low and come back, noting bus error pulses
	task automatic wait_run(input int lim);
		low = 1'b0;
		for (int i = 0; i < lim; i++) begin
			@(posedge clk);
			#1;
			if (bus_fault_in_q === 1'b1) seen = 1'b1;
			if (run_q === 1'b0) low = 1'b1;
			if (low && run_q === 1'b1) break;
		end
	endtask
	// one byte cycle from the execution core; stops early on a bus error
	task automatic exec_cycle(input logic we, input logic [19:0] pa, input logic [7:0] wd);
		seen = 1'b0;
		n = 0;
		@(posedge clk);
		exec_bus <= '{req: 1'b1, we: we, addr: pa, wdata: wd};
		for (int i = 0; i < 200 && exec_done_q !== 1'b1 && !seen; i++) begin
			@(posedge clk);
			#1;
			if (host_bus_q.req === 1'b1) begin
				hadr = host_bus_q.addr;
				n++;
			end
			if (bus_fault_in_q === 1'b1) seen = 1'b1;
		end
		@(posedge clk);
		exec_bus.req <= 1'b0;
	endtask
	task automatic s_on();
		@(posedge clk);
		board_on_command <= 1'b1;
		@(posedge clk);
		board_on_command <= 1'b0;
	endtask
	task automatic s_fetch();
		put32(16'h0800, 32'h00018800);
		put32(16'h0804, 32'h00010084);
		put32(16'h0808, 32'h00002000);
		put32(16'h0814, 32'h00001000);
		s_on();
		for (int i = 0; i < 20 && host_bus_q.req !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk("first_addr", 32'h0800, 32'(host_bus_q.addr));
		chk("run_early", 32'h0, 32'(run_q));
		wait_run(200);
		chk("ssp", 32'h00018800, supervisor_stack_ptr_q);
		chk("pc", 32'h00010084, program_counter_q);
		chk("board_on", 32'h1, 32'(board_on_q));
	endtask
	task automatic s_exec();
		u_cbw_host_mem.mem[16'h0923] = 8'h5a;
		delay <= 8'(WDOG - 5);
		exec_cycle(1'b0, 20'h00123, 8'h00);
		chk("rd_fault", 32'h0, 32'(seen));
		chk("rd_data", 32'h5a, 32'(exec_rdata_q));
		chk("rd_addr", 32'h0923, 32'(hadr));
		exec_cycle(1'b1, 20'h00124, 8'hc3);
		chk("wr_fault", 32'h0, 32'(seen));
		chk("wr_mem", 32'hc3, 32'(hb(20'h00124)));
		delay <= 8'h01;
	endtask
	task automatic s_exc();
		@(posedge clk);
		exc_req <= '{valid: 1'b1, vector: 8'h05, group0: 1'b0, info: 64'h0,
			status: 16'h2704, ret_pc: 32'h00001234};
		@(posedge clk);
		exc_req.valid <= 1'b0;
		wait_run(200);
		chk("exc_pc", 32'h00001000, program_counter_q);
		chk("exc_ssp", 32'h000187fa, supervisor_stack_ptr_q);
		chk("exc_sr", 32'h27, 32'(hb(20'h187fa)));
		chk("exc_ret", 32'h34, 32'(hb(20'h187ff)));
	endtask
	task automatic s_bus_fault_in();
		drop_addr <= 16'h0850;
		psw <= 16'h2010;
		exec_pc <= 32'h00003456;
		exec_cycle(1'b0, 20'h00050, 8'h00);
		chk("fault", 32'h1, 32'(seen));
		chk("fault_late", 32'h1, 32'(n >= WDOG));
		drop_addr <= 16'hffff;
		wait_run(400);
		chk("be_pc", 32'h00002000, program_counter_q);
		chk("be_ssp", 32'h000187ec, supervisor_stack_ptr_q);
		chk("be_addr", 32'h50, 32'(hb(20'h187f1)));
		chk("be_sr", 32'h20, 32'(hb(20'h187f4)));
		chk("be_ret", 32'h56, 32'(hb(20'h187f9)));
	endtask
	task automatic s_off();
		@(posedge clk);
		disk_busy <= 1'b1;
		@(posedge clk);
		disk_busy <= 1'b0;
		#1;
		chk("disk_off", 32'h0, 32'({board_on_q, run_q}));
		s_on();
		wait_run(200);
		chk("re_pc", 32'h00010084, program_counter_q);
		@(posedge clk);
		host_reset <= 1'b1;
		@(posedge clk);
		host_reset <= 1'b0;
		#1;
		chk("reset_off", 32'h0, 32'(board_on_q));
		// a vector byte that never answers must halt the board, not start it
		drop_addr <= 16'h0803;
		s_on();
		repeat (80) @(posedge clk);
		#1;
		chk("halt", 32'h2, 32'({halted_q, run_q}));
		@(posedge clk);
		drop_addr <= 16'hffff;
		host_reset <= 1'b1;
		@(posedge clk);
		host_reset <= 1'b0;
		#1;
		chk("halt_clear", 32'h0, 32'({halted_q, board_on_q}));
	endtask
	// clock generator
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// main sequence
	initial begin
		rstn = 1'b0;
		host_reset = 1'b0;
		board_on_command = 1'b0;
		disk_busy = 1'b0;
		exec_bus = '0;
		exc_req = '0;
		exec_pc = 32'h0;
		psw = 16'h0;
		delay = 8'h01;
		drop_addr = 16'hffff;
		fails = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		s_fetch();
		s_exec();
		s_exc();
		s_bus_fault_in();
		s_off();
		print_verdict();
	end
	// watchdog against a hang
	initial begin
		#100000;
		fails++;
		print_verdict();
	end
endmodule // coprocessor_bus_watchdog_reset_test
